//--- dv/pci_master_termination_handler_tb.sv
`timescale 1ns/100ps
module pci_master_termination_handler_tb;
  import pmth_pkg::*;
  logic ref_clk_i, nrst_i, gnt_n_i, devsel_n_i, trdy_n_i, stop_n_i;
  logic req_n_o, frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o;
  logic xfer_req_i, xfer_func_i, word_ack_o, xfer_done_o, xfer_abort_o;
  logic eth_fatal_reset_o, scsi_int_req_i, scsi_inta_n_o, reg_rd_i, reg_wr_i;
  logic [7:0] xfer_words_i, reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd;
  logic [1:0] mode;
  logic held;
  bit chain, gap;
  int err_total, comparisons;
  logic [7:0] offs[6] = '{8'h04, 8'h84, 8'h0c, 8'h8c, 8'h54, 8'h40};
  pmth_master_term #(.WORDS_W(8)) dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .gnt_n_i(gnt_n_i), .devsel_n_i(devsel_n_i), .trdy_n_i(trdy_n_i), .stop_n_i(stop_n_i),
    .req_n_o(req_n_o), .frame_n_o(frame_n_o), .frame_oe_o(frame_oe_o), .irdy_n_o(irdy_n_o),
    .irdy_oe_o(irdy_oe_o), .xfer_req_i(xfer_req_i), .xfer_func_i(xfer_func_i),
    .xfer_words_i(xfer_words_i), .word_ack_o(word_ack_o), .xfer_done_o(xfer_done_o),
    .xfer_abort_o(xfer_abort_o), .eth_fatal_reset_o(eth_fatal_reset_o),
    .scsi_int_req_i(scsi_int_req_i), .scsi_inta_n_o(scsi_inta_n_o), .reg_rd_i(reg_rd_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o));
  pmth_pci_model far_u (.clk_i(ref_clk_i), .nrst_i(nrst_i), .req_n_i(req_n_o),
    .frame_n_i(frame_oe_o ? frame_n_o : 1'b1), .irdy_n_i(irdy_oe_o ? irdy_n_o : 1'b1),
    .mode_i(mode), .gnt_n_o(gnt_n_i), .devsel_n_o(devsel_n_i), .trdy_n_o(trdy_n_i),
    .stop_n_o(stop_n_i), .held_o(held));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] stat_exp(input bit ta, input bit ma);
    return (32'(ta) << (PMTH_STAT_SHIFT + PMTH_RTA_BIT)) |
      (32'(ma) << (PMTH_STAT_SHIFT + PMTH_RMA_BIT));
  endfunction : stat_exp
  task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {wr, !wr, a, d};
    @(negedge ref_clk_i);
    rd = reg_rdata_o;
    {reg_wr_i, reg_rd_i} = 2'b00;
  endtask : reg_op
  task automatic xfer(input logic f, input logic [7:0] w, input logic [1:0] m, input bit ab);
    int n;
    int acks;
    bit fin;
    bit bad;
    logic fr_prev;
    bit gap_in;
    n = 0;
    acks = 0;
    fin = 0;
    bad = 0;
    fr_prev = 1'b1;
    // The call after a chained call follows it inside the address gap
    gap_in = gap;
    gap = chain;
    mode = m;
    {xfer_func_i, xfer_words_i, xfer_req_i} = {f, w, 1'b1};
    while (!fin && n < 800) begin
      @(negedge ref_clk_i);
      n++;
      acks += int'(word_ack_o === 1'b1);
      if (held && req_n_o !== 1'b0 && xfer_done_o !== 1'b1) bad = 1;
      if (fr_prev === 1'b0 && frame_n_o === 1'b1) chk(irdy_n_o, 1'b0);
      fr_prev = frame_n_o;
      if (n == 1 && gap_in) chk(frame_n_o, 1'b0);
      if (xfer_done_o === 1'b1 || xfer_abort_o === 1'b1) begin
        fin = 1;
        xfer_req_i = 1'b0;
        chk(xfer_abort_o, ab);
        chk({frame_oe_o, irdy_oe_o}, 2'b00);
        chk(eth_fatal_reset_o, ab & !f);
        chk(scsi_inta_n_o, 1'b1);
      end
    end
    chk(fin, 1'b1);
    chk(bad, 1'b0);
    if (!ab) chk(acks, w);
    repeat (gap ? 1 : 10) begin
      @(negedge ref_clk_i);
      if (req_n_o !== 1'b1) bad = 1;
    end
    chk(bad, 1'b0);
  endtask : xfer
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst_i, xfer_req_i, xfer_func_i, xfer_words_i, scsi_int_req_i} = '0;
    {reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i, mode} = '0;
    err_total = 0;
    comparisons = 0;
    void'($urandom(32'h8835));
    repeat (12) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    foreach (offs[i]) begin
      reg_op(1'b0, offs[i], 32'h0);
      chk(rd, PMTH_RD_ZERO);
    end
    reg_op(1'b1, PMTH_ETH_LAT_OFF, 32'hffff_ffff);
    reg_op(1'b1, 8'h40, 32'hffff_ffff);
    reg_op(1'b0, PMTH_ETH_LAT_OFF, 32'h0);
    chk(rd, PMTH_RD_ZERO);
    reg_op(1'b0, 8'h40, 32'h0);
    chk(rd, PMTH_RD_ZERO);
    scsi_int_req_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk(scsi_inta_n_o, 1'b0);
    scsi_int_req_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(scsi_inta_n_o, 1'b1);
    repeat (14) xfer(1'($urandom % 2), 8'(1 + $urandom % 6), ($urandom % 2) ? 2'd2 : 2'd0, 0);
    xfer(1'b0, 8'd1, 2'd0, 0);
    // Back to back while the grant is still seen: no new request phase
    chain = 1'b1;
    xfer(1'b0, 8'd3, 2'd0, 0);
    chain = 1'b0;
    xfer(1'b1, 8'd2, 2'd0, 0);
    for (int f = 0; f < 2; f++) begin
      for (int m = 1; m < 4; m += 2) begin
        xfer(1'(f), 8'(1 + $urandom % 4), 2'(m), 1);
        reg_op(1'b0, f ? PMTH_SCSI_CFG_STAT_OFF : PMTH_ETH_CFG_STAT_OFF, 32'h0);
        chk(rd & 32'hffff_0000, stat_exp(m == 1, m == 3));
        if (f == 1) begin
          reg_op(1'b0, PMTH_DMA_STAT_OFF, 32'h0);
          chk(rd[PMTH_DMA_ABORT_BIT], 1'b1);
          reg_op(1'b0, PMTH_DMA_STAT_OFF, 32'h0);
          chk(rd[PMTH_DMA_ABORT_BIT], 1'b0);
        end
        reg_op(1'b1, f ? PMTH_SCSI_CFG_STAT_OFF : PMTH_ETH_CFG_STAT_OFF, stat_exp(1, 1));
        reg_op(1'b0, f ? PMTH_SCSI_CFG_STAT_OFF : PMTH_ETH_CFG_STAT_OFF, 32'h0);
        chk(rd & 32'hffff_0000, stat_exp(0, 0));
      end
    end
    xfer(1'b1, 8'd5, 2'd2, 0);
    conclude();
  end
  initial begin
    #500000;
    err_total++;
    conclude();
  end
endmodule : pci_master_termination_handler_tb

//--- dv/pmth_pci_model.sv
`timescale 1ns/100ps
module pmth_pci_model (
  input wire logic clk_i, // Bus clock
  input wire logic nrst_i, // Reset, active low
  input wire logic req_n_i, // Request seen on the wire
  input wire logic frame_n_i, // Resolved frame level
  input wire logic irdy_n_i, // Resolved initiator ready level
  input wire logic [1:0] mode_i, // 0 normal, 1 target abort, 2 preempt, 3 no target
  output logic gnt_n_o, // Grant from the arbiter
  output logic devsel_n_o, // Target select
  output logic trdy_n_o, // Target ready
  output logic stop_n_o, // Target stop
  output logic held_o // Grant withdrawn for preemption
);
  int cnt;
  int data;
  int hold;
  assign held_o = (hold != 0);
  always @(negedge clk_i) begin
    if (!nrst_i) begin
      {gnt_n_o, devsel_n_o, trdy_n_o, stop_n_o} <= 4'hf;
      cnt <= 0;
      data <= 0;
      hold <= 0;
    end else begin
      if (hold != 0) hold <= hold - 1;
      gnt_n_o <= req_n_i | (hold != 0);
      if (frame_n_i && irdy_n_i) begin
        // Pulled-up lines idle high once released
        {devsel_n_o, trdy_n_o, stop_n_o} <= 3'h7;
        cnt <= 0;
        data <= 0;
      end else begin
        cnt <= cnt + 1;
        if (!irdy_n_i && !trdy_n_o) data <= data + 1;
        case (mode_i)
          2'd1: begin
            devsel_n_o <= (cnt != 1);
            stop_n_o <= (cnt < 2);
            trdy_n_o <= 1'b1;
          end
          2'd3: {devsel_n_o, trdy_n_o, stop_n_o} <= 3'h7;
          default: begin
            devsel_n_o <= (cnt < 1);
            trdy_n_o <= irdy_n_i | (cnt < 1) | (($urandom % 3) == 0);
            if (mode_i == 2'd2 && data == 2 && !irdy_n_i && !trdy_n_o) hold <= 20;
          end
        endcase
      end
    end
  end
endmodule : pmth_pci_model

//--- hw/pmth_master_term.sv
`timescale 1ns/100ps
module pmth_master_term #(
  parameter int WORDS_W = 8 // Width of the data phase count
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic gnt_n_i, // Bus grant pin
  input wire logic devsel_n_i, // Target select pin
  input wire logic trdy_n_i, // Target ready pin
  input wire logic stop_n_i, // Target stop pin
  output logic req_n_o, // Bus request pin
  output logic frame_n_o, // Frame pin level
  output logic frame_oe_o, // Frame pin drive enable
  output logic irdy_n_o, // Initiator ready pin level
  output logic irdy_oe_o, // Initiator ready pin drive enable
  input wire logic xfer_req_i, // Transfer request, held until done or abort
  input wire logic xfer_func_i, // Requesting function: 0 Ethernet, 1 SCSI
  input wire logic [WORDS_W-1:0] xfer_words_i, // Data phases wanted, nonzero
  output logic word_ack_o, // One data phase completed
  output logic xfer_done_o, // Transfer finished normally
  output logic xfer_abort_o, // Transfer ended by target or master abort
  output logic eth_fatal_reset_o, // Reset Ethernet control and bus-config registers
  input wire logic scsi_int_req_i, // SCSI core interrupt request
  output logic scsi_inta_n_o, // SCSI interrupt line
  input wire logic reg_rd_i, // Register read strobe
  input wire logic reg_wr_i, // Register write strobe
  input wire logic [7:0] reg_addr_i, // Register byte offset
  input wire logic [31:0] reg_wdata_i, // Register write data
  output logic [31:0] reg_rdata_o // Register read data, one cycle later
);
  import pmth_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic gnt_s;
  logic devsel_s;
  logic trdy_s;
  logic stop_s;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pin_meta_reg <= 4'hf;
      pin_sync_reg <= 4'hf;
    end else begin
      pin_meta_reg <= {gnt_n_i, devsel_n_i, trdy_n_i, stop_n_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign gnt_s = !pin_sync_reg[3];
  assign devsel_s = !pin_sync_reg[2];
  assign trdy_s = !pin_sync_reg[1];
  assign stop_s = !pin_sync_reg[0];

  // ---------------------------------------------------------------
  // Master sequencer
  // ---------------------------------------------------------------
  pmth_state_t state_reg, state_next;
  pmth_kind_t kind_reg, kind_next;
  logic func_reg, func_next;
  logic [WORDS_W-1:0] words_reg, words_next;
  logic [2:0] ma_cnt_reg, ma_cnt_next;
  logic dev_seen_reg, dev_seen_next;
  logic owner_reg, owner_next;
  logic req_n_next, frame_n_next, frame_oe_next, irdy_n_next, irdy_oe_next;
  logic ack_next, done_next, abort_next, eth_rst_next, inta_n_next;
  logic ta_cond;

  assign ta_cond = stop_s && !devsel_s && dev_seen_reg;

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    func_next = func_reg;
    words_next = words_reg;
    ma_cnt_next = ma_cnt_reg;
    dev_seen_next = dev_seen_reg;
    owner_next = owner_reg && gnt_s;
    ack_next = 1'b0;
    case (state_reg)
      PMTH_IDLE: begin
        if (xfer_req_i) begin
          func_next = xfer_func_i;
          words_next = xfer_words_i;
          kind_next = PMTH_K_OK;
          // Still owning the bus: next address phase after a FRAME gap
          state_next = (owner_reg && gnt_s) ? PMTH_ADDR : PMTH_REQ;
        end
      end
      PMTH_REQ: begin
        if (gnt_s) begin
          state_next = PMTH_ADDR;
          owner_next = 1'b1;
        end
      end
      PMTH_ADDR: begin
        state_next = PMTH_DATA;
        ma_cnt_next = 3'h0;
        dev_seen_next = devsel_s;
      end
      PMTH_DATA: begin
        if (devsel_s) begin
          dev_seen_next = 1'b1;
        end
        if (!dev_seen_reg && !devsel_s) begin
          if (ma_cnt_reg == PMTH_MA_CLKS - 3'h1) begin
            kind_next = PMTH_K_MA;
            state_next = PMTH_END1;
          end else begin
            ma_cnt_next = ma_cnt_reg + 3'h1;
          end
        end else if (ta_cond) begin
          kind_next = PMTH_K_TA;
          state_next = PMTH_END1;
        end else if (stop_s) begin
          kind_next = PMTH_K_DISC;
          state_next = PMTH_END1;
          if (trdy_s) begin
            ack_next = 1'b1;
            words_next = words_reg - {{(WORDS_W-1){1'b0}}, 1'b1};
          end
        end else if (trdy_s) begin
          ack_next = 1'b1;
          words_next = words_reg - {{(WORDS_W-1){1'b0}}, 1'b1};
          if (words_reg == {{(WORDS_W-1){1'b0}}, 1'b1}) begin
            kind_next = PMTH_K_OK;
            state_next = PMTH_END1;
          end else if (!gnt_s) begin
            kind_next = PMTH_K_PRE;
            state_next = PMTH_END1;
          end
        end
      end
      PMTH_END1: state_next = PMTH_END2;
      PMTH_END2: state_next = PMTH_REL;
      PMTH_REL: begin
        dev_seen_next = 1'b0;
        case (kind_reg)
          // Unfinished words are fetched again; the request stays low
          PMTH_K_DISC, PMTH_K_PRE: begin
            state_next = (words_reg == {WORDS_W{1'b0}}) ? PMTH_IDLE : PMTH_REQ;
          end
          PMTH_K_TA, PMTH_K_MA: begin
            state_next = PMTH_IDLE;
            owner_next = 1'b0;
          end
          default: state_next = PMTH_IDLE;
        endcase
      end
      default: state_next = PMTH_IDLE;
    endcase
  end

  // Outputs follow the next state so each bus pin shows its state's value; the SCSI interrupt line follows its request
  always_comb begin
    req_n_next = !(state_next == PMTH_REQ || state_next == PMTH_ADDR
      || state_next == PMTH_DATA || state_next == PMTH_END1
      || state_next == PMTH_END2
      || (state_next == PMTH_REL && kind_next inside {PMTH_K_DISC, PMTH_K_PRE}));
    frame_oe_next = state_next inside {PMTH_ADDR, PMTH_DATA, PMTH_END1, PMTH_END2};
    irdy_oe_next = frame_oe_next;
    frame_n_next = !(state_next == PMTH_ADDR || state_next == PMTH_DATA);
    irdy_n_next = !(state_next == PMTH_DATA || state_next == PMTH_END1);
    done_next = (state_next == PMTH_REL) && (kind_next == PMTH_K_OK
      || (kind_next inside {PMTH_K_DISC, PMTH_K_PRE} && words_next == {WORDS_W{1'b0}}));
    abort_next = (state_next == PMTH_REL) && (kind_next inside {PMTH_K_TA, PMTH_K_MA});
    eth_rst_next = abort_next && !func_next;
    inta_n_next = !scsi_int_req_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_reg <= PMTH_IDLE;
      kind_reg <= PMTH_K_OK;
      func_reg <= 1'b0;
      words_reg <= '0;
      ma_cnt_reg <= 3'h0;
      dev_seen_reg <= 1'b0;
      owner_reg <= 1'b0;
      req_n_o <= 1'b1;
      frame_n_o <= 1'b1;
      frame_oe_o <= 1'b0;
      irdy_n_o <= 1'b1;
      irdy_oe_o <= 1'b0;
      word_ack_o <= 1'b0;
      xfer_done_o <= 1'b0;
      xfer_abort_o <= 1'b0;
      eth_fatal_reset_o <= 1'b0;
      scsi_inta_n_o <= 1'b1;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      func_reg <= func_next;
      words_reg <= words_next;
      ma_cnt_reg <= ma_cnt_next;
      dev_seen_reg <= dev_seen_next;
      owner_reg <= owner_next;
      req_n_o <= req_n_next;
      frame_n_o <= frame_n_next;
      frame_oe_o <= frame_oe_next;
      irdy_n_o <= irdy_n_next;
      irdy_oe_o <= irdy_oe_next;
      word_ack_o <= ack_next;
      xfer_done_o <= done_next;
      xfer_abort_o <= abort_next;
      eth_fatal_reset_o <= eth_rst_next;
      scsi_inta_n_o <= inta_n_next;
    end
  end

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------
  logic eth_rta_reg, eth_rta_next, eth_rma_reg, eth_rma_next;
  logic scsi_rta_reg, scsi_rta_next, scsi_rma_reg, scsi_rma_next;
  logic dma_abort_reg, dma_abort_next;
  logic [31:0] rdata_next;
  logic set_ta, set_ma, wr_eth, wr_scsi, rd_dma;

  assign set_ta = abort_next && (kind_next == PMTH_K_TA);
  assign set_ma = abort_next && (kind_next == PMTH_K_MA);
  assign wr_eth = reg_wr_i && (reg_addr_i == PMTH_ETH_CFG_STAT_OFF);
  assign wr_scsi = reg_wr_i && (reg_addr_i == PMTH_SCSI_CFG_STAT_OFF);
  assign rd_dma = reg_rd_i && (reg_addr_i == PMTH_DMA_STAT_OFF);

  // Config status abort bits clear by writing one; a new abort in that cycle wins
  always_comb begin
    eth_rta_next = (eth_rta_reg && !(wr_eth && reg_wdata_i[PMTH_STAT_SHIFT + PMTH_RTA_BIT]))
      || (set_ta && !func_next);
    eth_rma_next = (eth_rma_reg && !(wr_eth && reg_wdata_i[PMTH_STAT_SHIFT + PMTH_RMA_BIT]))
      || (set_ma && !func_next);
    scsi_rta_next = (scsi_rta_reg && !(wr_scsi && reg_wdata_i[PMTH_STAT_SHIFT + PMTH_RTA_BIT]))
      || (set_ta && func_next);
    scsi_rma_next = (scsi_rma_reg && !(wr_scsi && reg_wdata_i[PMTH_STAT_SHIFT + PMTH_RMA_BIT]))
      || (set_ma && func_next);
    // Abort flag clears on read of the DMA status register
    dma_abort_next = (dma_abort_reg && !rd_dma) || (abort_next && func_next);
    rdata_next = PMTH_RD_ZERO;
    if (reg_rd_i) begin
      case (reg_addr_i)
        PMTH_ETH_CFG_STAT_OFF: begin
          rdata_next[PMTH_STAT_SHIFT + PMTH_RTA_BIT] = eth_rta_reg;
          rdata_next[PMTH_STAT_SHIFT + PMTH_RMA_BIT] = eth_rma_reg;
        end
        PMTH_SCSI_CFG_STAT_OFF: begin
          rdata_next[PMTH_STAT_SHIFT + PMTH_RTA_BIT] = scsi_rta_reg;
          rdata_next[PMTH_STAT_SHIFT + PMTH_RMA_BIT] = scsi_rma_reg;
        end
        PMTH_ETH_LAT_OFF, PMTH_SCSI_LAT_OFF: begin
          rdata_next[PMTH_LAT_LSB +: 8] = PMTH_LAT_VALUE;
        end
        PMTH_DMA_STAT_OFF: rdata_next[PMTH_DMA_ABORT_BIT] = dma_abort_reg;
        default: rdata_next = PMTH_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      eth_rta_reg <= 1'b0;
      eth_rma_reg <= 1'b0;
      scsi_rta_reg <= 1'b0;
      scsi_rma_reg <= 1'b0;
      dma_abort_reg <= 1'b0;
      reg_rdata_o <= PMTH_RD_ZERO;
    end else begin
      eth_rta_reg <= eth_rta_next;
      eth_rma_reg <= eth_rma_next;
      scsi_rta_reg <= scsi_rta_next;
      scsi_rma_reg <= scsi_rma_next;
      dma_abort_reg <= dma_abort_next;
      reg_rdata_o <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ta_end_seq: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMTH_DATA && ta_cond) |-> ##1 (frame_n_o && !irdy_n_o)
      ##1 (frame_n_o && irdy_n_o && frame_oe_o) ##1 !frame_oe_o)
    else $error("target abort ending out of order");
  a_ta_no_retry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMTH_REL && kind_reg == PMTH_K_TA) |=> (state_reg == PMTH_IDLE && req_n_o))
    else $error("target abort was retried");
  a_eth_fatal: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(xfer_abort_o) |-> (eth_fatal_reset_o == !func_reg))
    else $error("Ethernet fatal reset missing or wrong");
  a_scsi_flag_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (xfer_abort_o && func_reg) |-> (dma_abort_reg
      && scsi_inta_n_o == !$past(scsi_int_req_i)))
    else $error("SCSI abort flag not set or interrupt raised");
  a_rta_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (xfer_abort_o && kind_reg == PMTH_K_TA) |-> (func_reg ? scsi_rta_reg : eth_rta_reg))
    else $error("received target abort bit not set");
  a_pre_keep_req: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMTH_END2 && kind_reg == PMTH_K_PRE && words_reg != '0)
      |=> !req_n_o ##1 (!req_n_o && state_reg inside {PMTH_REQ, PMTH_ADDR}))
    else $error("request dropped after preemption");
  a_lat_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == PMTH_ETH_LAT_OFF) |=> (reg_rdata_o == PMTH_RD_ZERO))
    else $error("latency timer reads nonzero");
  a_ma_timeout: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMTH_ADDR && !devsel_s) ##1 (state_reg == PMTH_DATA && !devsel_s)[*4]
      |=> (state_reg == PMTH_END1 && kind_reg == PMTH_K_MA))
    else $error("master abort not taken after four clocks");
  a_rma_sets: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (xfer_abort_o && kind_reg == PMTH_K_MA) |-> (func_reg ? scsi_rma_reg : eth_rma_reg))
    else $error("received master abort bit not set");
  a_idle_release: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $fell(frame_oe_o) |-> ($past(frame_n_o) && $past(irdy_n_o) && !irdy_oe_o))
    else $error("bus released without idle levels");
  a_ma_end_seq: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMTH_END1 && kind_reg == PMTH_K_MA)
      |-> (frame_n_o && !irdy_n_o) ##1 (irdy_n_o && irdy_oe_o) ##1 !irdy_oe_o)
    else $error("master abort ending out of order");

endmodule : pmth_master_term

//--- hw/pmth_pkg.sv
package pmth_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PMTH_ETH_CFG_STAT_OFF = 8'h04;
  localparam logic [7:0] PMTH_SCSI_CFG_STAT_OFF = 8'h84;
  localparam logic [7:0] PMTH_ETH_LAT_OFF = 8'h0c;
  localparam logic [7:0] PMTH_SCSI_LAT_OFF = 8'h8c;
  localparam logic [7:0] PMTH_DMA_STAT_OFF = 8'h54;
  localparam int PMTH_DMA_ABORT_BIT = 2;
  localparam int PMTH_STAT_SHIFT = 16;
  localparam int PMTH_RTA_BIT = 12;
  localparam int PMTH_RMA_BIT = 13;
  localparam int PMTH_LAT_LSB = 8;
  localparam logic [7:0] PMTH_LAT_VALUE = 8'h00;
  localparam logic [31:0] PMTH_RD_ZERO = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [2:0] PMTH_MA_CLKS = 3'h4;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PMTH_IDLE = 3'b000,
    PMTH_REQ = 3'b001,
    PMTH_ADDR = 3'b010,
    PMTH_DATA = 3'b011,
    PMTH_END1 = 3'b100,
    PMTH_END2 = 3'b101,
    PMTH_REL = 3'b110
  } pmth_state_t;
  typedef enum logic [2:0] {
    PMTH_K_OK = 3'b000,
    PMTH_K_DISC = 3'b001,
    PMTH_K_PRE = 3'b010,
    PMTH_K_TA = 3'b011,
    PMTH_K_MA = 3'b100
  } pmth_kind_t;
endpackage : pmth_pkg
